// ---- bench/dma_ctrl_model.sv ----
// dma controller model serving both timer channels
`timescale 1ns/1ns
module dma_ctrl_model
  import timer_dma_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // link
  input  wire logic        slow,
  input  wire dma_out_t    dma_out,
  output dma_in_t          dma_in,
  // observation
  output logic      [15:0] word,
  output logic      [7:0]  words
);
  logic [1:0] gap;
  wire        req = dma_out.req_capture | dma_out.req_compare;
  // no ack in the cycle after an ack: the design must update first
  wire        go  = req & ~dma_in.ack & (gap == 2'h0 | ~slow);
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      dma_in <= '0;
      gap    <= 2'h3;
      word   <= 16'hffff;
      words  <= 8'h00;
    end
    else
    begin
      dma_in.ack     <= go;
      dma_in.last    <= go & ~dma_out.high_byte;
      dma_in.wr_byte <= go ? (dma_out.high_byte ? 8'hab : 8'hcd) : ~dma_in.wr_byte;
      gap            <= go ? 2'h3 : (gap == 2'h0 ? gap : gap - 2'h1);
      if (dma_in.ack & dma_out.high_byte)
        word[15:8] <= dma_out.rd_byte;
      if (dma_in.ack & ~dma_out.high_byte)
        word[7:0] <= dma_out.rd_byte;
      if (dma_in.ack & ~dma_out.high_byte)
        words <= words + 8'h01;
    end
  end
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench of the timer dma and counter-control block
`timescale 1ns/1ns
module tb_top
  import timer_dma_pkg::*;
();
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata;
  logic        pready, pslverr, irq_capture0, irq_compare0;
  logic        cap0_trig_pin = 1'b0, cap1_trig_pin = 1'b0;
  logic        dir_fixed_pin = 1'b0, dir_up_pin = 1'b0;
  dma_in_t     dma_in;
  dma_out_t    dma_out;
  logic [15:0] word;
  logic [7:0]  words;
  int          n_fail = 0, checks = 0;
  always #5 clk = ~clk;
  timer_dma_capture_compare timer_dma_capture_compare_inst (.clk, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cap0_trig_pin, .cap1_trig_pin,
    .dir_fixed_pin, .dir_up_pin, .dma_in, .dma_out, .irq_capture0, .irq_compare0);
  dma_ctrl_model dma_ctrl_model_inst (.clk, .reset, .slow, .dma_out, .dma_in, .word, .words);
  task automatic final_report();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [8:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {22'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = {pslverr, prdata[7:0]};
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_fail++;
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [8:0] rd;
    apb(1'b1, idx, wd, rd);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input logic err);
    logic [8:0] rd;
    apb(1'b0, idx, 8'h00, rd);
    check({23'h0, rd}, {23'h0, err, exp});
  endtask
  // which: 0 capture irq, 1 compare irq, 2 word count
  task automatic wait_for(input int which, input logic [7:0] target);
    int n;
    n = 0;
    while ((which == 0 ? {7'h0, irq_capture0} : which == 1 ? {7'h0, irq_compare0} : words)
           !== target && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 2000)
    begin
      n_fail++;
      final_report();
    end
  endtask
  // pins are synchronised, so the pulse spans several clocks
  task automatic pulse_capture();
    cap0_trig_pin <= 1'b1;
    cap1_trig_pin <= 1'b1;
    repeat (3) @(posedge clk);
    cap0_trig_pin <= 1'b0;
    cap1_trig_pin <= 1'b0;
  endtask
  task automatic s_reset_values();
    rd_chk(IDX_CTRL, 8'h00, 1'b0);
    rd_chk(IDX_CENTRAL, 8'h01, 1'b0);
    rd_chk(IDX_CMP0_LOW, 8'h00, 1'b0);
    rd_chk(8'h20, 8'h00, 1'b1);
  endtask
  task automatic s_counter_control();
    wr(IDX_CMP0_HIGH, 8'h80);
    dir_fixed_pin <= 1'b1;
    dir_up_pin    <= 1'b1;
    wr(IDX_CTRL, 8'h98);
    rd_chk(IDX_CTRL, 8'h8d, 1'b0);
    wr(IDX_CENTRAL, 8'h00);
    rd_chk(IDX_CTRL, 8'h8c, 1'b0);
    wr(IDX_CENTRAL, 8'h01);
    wr(IDX_CTRL, 8'h90);
    rd_chk(IDX_CTRL, 8'h85, 1'b0);
    wr(IDX_CTRL, 8'h10);
    dir_fixed_pin <= 1'b0;
    wr(IDX_CTRL, 8'h08);
    rd_chk(IDX_CTRL, 8'h0c, 1'b0);
  endtask
  task automatic s_capture_word();
    wr(IDX_CAP0_HIGH, 8'h55);
    wr(IDX_CAP1_LOW, 8'h55);
    wr(IDX_MASK, 8'h03);
    pulse_capture();
    wait_for(0, 8'h01);
    check({16'h0, word}, 32'h0000_0000);
    check({24'h0, words}, 32'h0000_0001);
    rd_chk(IDX_CAP0_HIGH, 8'h00, 1'b0);
    rd_chk(IDX_CAP1_LOW, 8'h00, 1'b0);
    rd_chk(IDX_DMA_CTRL, 8'h01, 1'b0);
  endtask
  task automatic s_overrun();
    pulse_capture();
    wait_for(2, 8'h02);
    rd_chk(IDX_MASK, 8'h01, 1'b0);
    rd_chk(IDX_FLAG, 8'h05, 1'b0);
    wr(IDX_DMA_CTRL, 8'h00);
    wr(IDX_FLAG, 8'h00);
    wr(IDX_MASK, 8'h0f);
  endtask
  task automatic s_compare_swap();
    wr(IDX_DMA_CTRL, 8'h24);
    wr(IDX_CNT_PTR, 8'h01);
    wr(IDX_ADDR_PTR, 8'hf0);
    wr(IDX_CMP0_HIGH, 8'h00);
    wr(IDX_CMP0_LOW, 8'h10);
    slow <= 1'b1;
    wr(IDX_CTRL, 8'h98);
    wait_for(1, 8'h01);
    wr(IDX_CTRL, 8'h08);
    rd_chk(IDX_CMP0_HIGH, 8'hab, 1'b0);
    rd_chk(IDX_CMP0_LOW, 8'hcd, 1'b0);
    rd_chk(IDX_CNT_PTR, 8'h05, 1'b0);
    rd_chk(IDX_ADDR_PTR, 8'hf0, 1'b0);
    rd_chk(IDX_DMA_CTRL, 8'h26, 1'b0);
  endtask
  task automatic s_spurious();
    wr(IDX_DMA_CTRL, 8'h04);
    wr(IDX_FLAG, 8'h00);
    wr(IDX_DMA_CTRL, 8'h05);
    rd_chk(IDX_FLAG, 8'h01, 1'b0);
    wait_for(0, 8'h01);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    s_reset_values();
    s_counter_control();
    s_capture_word();
    s_overrun();
    s_compare_swap();
    s_spurious();
    final_report();
  end
endmodule

// ---- bench/timer_dma_properties.sv ----
// port checker of the timer dma and counter-control block
`timescale 1ns/1ns
module timer_dma_properties
  import timer_dma_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic        cap0_trig_pin,
  input wire logic        cap1_trig_pin,
  input wire logic        dir_fixed_pin,
  input wire logic        dir_up_pin,
  // dma and irq
  input wire dma_in_t     dma_in,
  input wire dma_out_t    dma_out,
  input wire logic        irq_capture0,
  input wire logic        irq_compare0
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire busy = dma_out.req_capture | dma_out.req_compare;
  wire hb   = dma_out.high_byte;
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_capture_first: assert property (
    busy && hb && dma_out.req_capture && !$past(busy) |-> !dma_out.sel_compare)
    else $error("compare served before capture");
  a_word_kept: assert property (busy && !hb |-> $stable(dma_out.sel_compare))
    else $error("channel changed inside a word");
  a_second_prio: assert property (busy && !hb |-> dma_out.prio == PRIO_TOP)
    else $error("second byte priority not top");
  a_byte_order: assert property (busy && hb && dma_in.ack |=> busy && !hb)
    else $error("no second byte after first");
  a_req_stands: assert property (dma_out.req_capture && !dma_in.ack |=> dma_out.req_capture)
    else $error("capture request dropped early");
  a_req_drops: assert property (
    dma_out.req_capture && !dma_out.sel_compare && !hb && dma_in.ack |=>
    !dma_out.req_capture || hb) else $error("capture request held after word");
  a_ptr_channel: assert property (busy |-> dma_out.cnt_ptr[1] == dma_out.sel_compare)
    else $error("pointer bit 1 wrong");
  a_regpair_addr: assert property (dma_out.cnt_ptr[0] |-> dma_out.addr_ptr == 8'h00)
    else $error("address pointer used in register mode");
  c_cap_eob: cover property (dma_out.req_capture && dma_in.ack && dma_in.last);
  c_cmp_eob: cover property (dma_out.req_compare && dma_in.ack && dma_in.last);
  c_bad_addr: cover property (pslverr);
endmodule
bind timer_dma_capture_compare timer_dma_properties timer_dma_properties_inst (.clk, .reset,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cap0_trig_pin,
  .cap1_trig_pin, .dir_fixed_pin, .dir_up_pin, .dma_in, .dma_out, .irq_capture0, .irq_compare0);

// ---- common/timer_dma_pkg.sv ----
// constants, field layout and carrier types of the timer dma and counter-control block
//
// Contract
// - two independent dma channels: memory into compare 0, capture 0 out to memory
// - with dma enabled, capture/compare interrupts come only from end of block
// - capture 0 request has fixed higher priority than compare 0 request
// - each request gated by its dma mask bit, each end-of-block irq by its irq mask
// - upper five pointer bits of both pointer registers shared by both channels
// - with word address select zero, pointer bit 1 low for capture, high for compare
// - counter pointer bit 0 set selects register pairs; address pointer then unused
// - word moves as two bytes; second byte forces priority 000, then restores it
// - a started word keeps its channel until both bytes are done
// - transaction counter reaching zero ends the block with an end-of-block event
// - swap mode toggles pointer bit 2 per channel after each end of block
// - one swap enable bit switches swap mode for both channels
// - each end of block raises that channel's interrupt at its usual priority
// - end-of-block flags writable; writing one with swap enabled gives a spurious irq
// - end of block on a still-set flag clears that channel's dma mask
// - counter enable bit 7 anded with global run; stops or starts without reload
// - captures still happen while the counter is stopped
// - clear-on-capture bit 6 clears counter and reloads prescaler on any capture
// - clear-on-compare bit 5 clears counter and reloads prescaler on compare 0 match
// - counter clear bit 4 clears the counter without irq and always reads zero
// - bit 3 selects direction unless pins fix it; bit 2 reports actual direction
// - bit 1 flags a wrap at capture 0; bit 0 shows counter running
// - a source event while its pending bit is set sets its overrun bit
package timer_dma_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CAP0_HIGH = 8'hf0;
  localparam logic [7:0] IDX_CAP0_LOW  = 8'hf1;
  localparam logic [7:0] IDX_CAP1_HIGH = 8'hf2;
  localparam logic [7:0] IDX_CAP1_LOW  = 8'hf3;
  localparam logic [7:0] IDX_CMP0_HIGH = 8'hf4;
  localparam logic [7:0] IDX_CMP0_LOW  = 8'hf5;
  localparam logic [7:0] IDX_CMP1_HIGH = 8'hf6;
  localparam logic [7:0] IDX_CMP1_LOW  = 8'hf7;
  localparam logic [7:0] IDX_CTRL      = 8'hf8;
  localparam logic [7:0] IDX_CNT_PTR   = 8'hf9;
  localparam logic [7:0] IDX_ADDR_PTR  = 8'hfa;
  localparam logic [7:0] IDX_MASK      = 8'hfb;
  localparam logic [7:0] IDX_DMA_CTRL  = 8'hfc;
  localparam logic [7:0] IDX_FLAG      = 8'hfd;
  localparam logic [7:0] IDX_CENTRAL   = 8'hfe;

  // counter_control fields
  localparam int CTRL_RUN_EN   = 7;
  localparam int CTRL_CLR_CAP  = 6;
  localparam int CTRL_CLR_CMP  = 5;
  localparam int CTRL_CLEAR    = 4;
  localparam int CTRL_DIR_SEL  = 3;

  // irq_dma_mask_reg fields
  localparam int MASK_CAP_IRQ  = 0;
  localparam int MASK_CAP_DMA  = 1;
  localparam int MASK_CMP_IRQ  = 2;
  localparam int MASK_CMP_DMA  = 3;

  // irq_dma_control_reg fields
  localparam int DCTL_EOB_CAP  = 0;
  localparam int DCTL_EOB_CMP  = 1;
  localparam int DCTL_SWAP     = 2;
  localparam int DCTL_PRIO_LSB = 3;

  // timer_flag_reg fields
  localparam int FLAG_PEND_CAP = 0;
  localparam int FLAG_PEND_CMP = 1;
  localparam int FLAG_OVR_CAP  = 2;
  localparam int FLAG_OVR_CMP  = 3;

  // reset and load values
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [2:0]  PRIO_TOP      = 3'h0;
  localparam logic [7:0]  PRESC_LOAD    = 8'h00;
  localparam logic [15:0] COUNT_TOP     = 16'hffff;
  localparam logic [15:0] COUNT_ZERO    = 16'h0000;

  typedef enum logic [1:0] {XFER_IDLE, XFER_FIRST, XFER_SECOND} xfer_state_t;

  typedef struct packed {
    logic       req_capture;
    logic       req_compare;
    logic       sel_compare;
    logic       high_byte;
    logic [2:0] prio;
    logic [7:0] cnt_ptr;
    logic [7:0] addr_ptr;
    logic [7:0] rd_byte;
  } dma_out_t;

  typedef struct packed {
    logic       ack;
    logic       last;
    logic [7:0] wr_byte;
  } dma_in_t;

endpackage

// ---- logic/timer_dma_capture_compare.sv ----
// timer counter core, capture/compare registers and the two dma channels
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
module timer_dma_capture_compare
  import timer_dma_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic        cap0_trig_pin,
  input  wire logic        cap1_trig_pin,
  input  wire logic        dir_fixed_pin,
  input  wire logic        dir_up_pin,
  // dma controller
  input  wire dma_in_t     dma_in,
  output dma_out_t         dma_out,
  // interrupt requests
  output logic             irq_capture0,
  output logic             irq_compare0
);

  function automatic logic [7:0] pick(input logic [7:0] idx,
                                      input logic [7:0] k, input logic [7:0] v);
    pick = (idx == k) ? v : 8'h00;
  endfunction

  // register state
  logic [7:0]  cap0_hi, cap0_lo, cap1_hi, cap1_lo;
  logic [7:0]  cmp0_hi, cmp0_lo, cmp1_hi, cmp1_lo;
  logic        run_en, clr_on_cap, clr_on_cmp, dir_sel, dir_stat, wrap_cap, clear_req;
  logic [7:0]  cnt_ptr, addr_ptr;
  logic [3:0]  dma_mask;
  logic        eob_cap, eob_cmp, swap_en;
  logic [2:0]  prio;
  logic        pend_cap, pend_cmp, ovr_cap, ovr_cmp, glob_run;
  logic [15:0] counter;
  logic [7:0]  presc;
  logic        wrap_seen;
  logic [3:0]  sync1, sync2;
  logic [1:0]  trig_old;
  logic        req_cap, req_cmp, sel_cmp;
  xfer_state_t state, next_state;

  // apb decode; one wait state so read data comes from a flop
  wire        access   = psel & penable & ~pready;
  wire        wr_en    = psel & penable & pready & pwrite;
  wire [7:0]  idx      = paddr[9:2];
  wire [7:0]  wb       = pwdata[7:0];
  wire        mapped   = (idx >= IDX_CAP0_HIGH) && (idx <= IDX_CENTRAL);
  wire        w_cap0h  = wr_en & (idx == IDX_CAP0_HIGH);
  wire        w_cap0l  = wr_en & (idx == IDX_CAP0_LOW);
  wire        w_cap1h  = wr_en & (idx == IDX_CAP1_HIGH);
  wire        w_cap1l  = wr_en & (idx == IDX_CAP1_LOW);
  wire        w_cmp0h  = wr_en & (idx == IDX_CMP0_HIGH);
  wire        w_cmp0l  = wr_en & (idx == IDX_CMP0_LOW);
  wire        w_cmp1h  = wr_en & (idx == IDX_CMP1_HIGH);
  wire        w_cmp1l  = wr_en & (idx == IDX_CMP1_LOW);
  wire        w_ctrl   = wr_en & (idx == IDX_CTRL);
  wire        w_cptr   = wr_en & (idx == IDX_CNT_PTR);
  wire        w_aptr   = wr_en & (idx == IDX_ADDR_PTR);
  wire        w_mask   = wr_en & (idx == IDX_MASK);
  wire        w_dctl   = wr_en & (idx == IDX_DMA_CTRL);
  wire        w_flag   = wr_en & (idx == IDX_FLAG);
  wire        w_cent   = wr_en & (idx == IDX_CENTRAL);

  // counter core
  wire        running  = run_en & glob_run;
  wire        up       = sync2[2] ? sync2[3] : dir_sel;
  wire        tick     = running & (presc == 8'h00);
  wire        cap0_ev  = sync2[0] & ~trig_old[0];
  wire        cap1_ev  = sync2[1] & ~trig_old[1];
  wire        cmp_ev   = tick & (counter == {cmp0_hi, cmp0_lo});
  wire        wrap     = tick & (up ? counter == COUNT_TOP : counter == COUNT_ZERO);
  wire        clr_cap  = clr_on_cap & (cap0_ev | cap1_ev);
  wire        clr_cmp  = clr_on_cmp & cmp_ev;
  wire        clear    = clear_req | clr_cap | clr_cmp;
  wire [15:0] next_counter = clear ? COUNT_ZERO :
                             tick  ? (up ? counter + 16'h0001 : counter - 16'h0001) :
                             counter;
  wire [7:0]  next_presc = clear   ? PRESC_LOAD :
                           running ? ((presc == 8'h00) ? PRESC_LOAD : presc - 8'h01) :
                           presc;

  // dma channel control
  wire        cap_dma  = dma_mask[MASK_CAP_DMA];
  wire        cmp_dma  = dma_mask[MASK_CMP_DMA];
  wire        ack      = dma_in.ack & (state != XFER_IDLE);
  wire        done     = ack & (state == XFER_SECOND);
  wire        done_cap = done & ~sel_cmp;
  wire        done_cmp = done & sel_cmp;
  wire        eob_c    = done_cap & dma_in.last;
  wire        eob_m    = done_cmp & dma_in.last;
  wire        set_rcap = cap0_ev & cap_dma;
  wire        set_rcmp = cmp_ev & cmp_dma;
  wire        next_rcap = set_rcap | (req_cap & ~done_cap);
  wire        next_rcmp = set_rcmp | (req_cmp & ~done_cmp);
  // channel chosen as a word starts, so requests, byte flag and pointers leave together
  wire        new_word = (next_state == XFER_FIRST) & (state != XFER_FIRST);
  wire        next_sel = new_word ? ~next_rcap : sel_cmp;

  always_comb
  begin
    next_state = state;
    case (state)
      XFER_IDLE:   if (next_rcap | next_rcmp) next_state = XFER_FIRST;
      XFER_FIRST:  if (ack) next_state = XFER_SECOND;
      XFER_SECOND: if (ack) next_state = (next_rcap | next_rcmp) ? XFER_FIRST :
                                         XFER_IDLE;
      default:     next_state = XFER_IDLE;
    endcase
  end

  // pointer mapping, held per channel
  wire        tog      = next_sel ? cnt_ptr[2] : addr_ptr[2];
  wire        reg_pair = cnt_ptr[0];
  wire [7:0]  next_cptr = {cnt_ptr[7:3], tog, next_sel, cnt_ptr[0]};
  wire [7:0]  next_aptr = reg_pair ? 8'h00 :
                          {addr_ptr[7:3], tog, next_sel, addr_ptr[0]};
  wire        next_high = (next_state == XFER_FIRST);
  wire [2:0]  next_prio = (next_state == XFER_SECOND) ? PRIO_TOP : prio;

  // end of block, swap and protection
  wire        spur_cap = w_dctl & wb[DCTL_EOB_CAP] & ~eob_cap & swap_en;
  wire        spur_cmp = w_dctl & wb[DCTL_EOB_CMP] & ~eob_cmp & swap_en;
  wire        prot_cap = eob_c & eob_cap;
  wire        prot_cmp = eob_m & eob_cmp;
  wire        ev_cap   = cap_dma ? (eob_c | spur_cap) : (cap0_ev | spur_cap);
  wire        ev_cmp   = cmp_dma ? (eob_m | spur_cmp) : (cmp_ev | spur_cmp);

  // read mux
  wire [7:0]  ctrl_rd  = {run_en, clr_on_cap, clr_on_cmp, 1'b0,
                          dir_sel, dir_stat, wrap_cap, running};
  wire [7:0]  dctl_rd  = {2'b00, prio, swap_en, eob_cmp, eob_cap};
  wire [7:0]  flag_rd  = {4'h0, ovr_cmp, ovr_cap, pend_cmp, pend_cap};
  wire [7:0]  rd_byte  = pick(idx, IDX_CAP0_HIGH, cap0_hi) | pick(idx, IDX_CAP0_LOW, cap0_lo)
                       | pick(idx, IDX_CAP1_HIGH, cap1_hi) | pick(idx, IDX_CAP1_LOW, cap1_lo)
                       | pick(idx, IDX_CMP0_HIGH, cmp0_hi) | pick(idx, IDX_CMP0_LOW, cmp0_lo)
                       | pick(idx, IDX_CMP1_HIGH, cmp1_hi) | pick(idx, IDX_CMP1_LOW, cmp1_lo)
                       | pick(idx, IDX_CTRL, ctrl_rd)      | pick(idx, IDX_CNT_PTR, cnt_ptr)
                       | pick(idx, IDX_ADDR_PTR, addr_ptr)
                       | pick(idx, IDX_MASK, {4'h0, dma_mask})
                       | pick(idx, IDX_DMA_CTRL, dctl_rd)  | pick(idx, IDX_FLAG, flag_rd)
                       | pick(idx, IDX_CENTRAL, {7'h00, glob_run});

  // apb answer
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= access;
      prdata  <= access ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr <= access & ~mapped;
    end
  end

  // pin synchronisers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sync1    <= 4'h0;
      sync2    <= 4'h0;
      trig_old <= 2'b00;
    end
    else
    begin
      sync1    <= {dir_up_pin, dir_fixed_pin, cap1_trig_pin, cap0_trig_pin};
      sync2    <= sync1;
      trig_old <= sync2[1:0];
    end
  end

  // counter, prescaler and status
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      counter   <= COUNT_ZERO;
      presc     <= PRESC_LOAD;
      dir_stat  <= 1'b0;
      wrap_cap  <= 1'b0;
      wrap_seen <= 1'b0;
    end
    else
    begin
      counter  <= next_counter;
      presc    <= next_presc;
      dir_stat <= up;
      if (cap0_ev)
      begin
        wrap_cap  <= wrap_seen | wrap;
        wrap_seen <= 1'b0;
      end
      else if (wrap)
        wrap_seen <= 1'b1;
    end
  end

  // capture/load and compare registers; a capture wins over a software write
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cap0_hi <= RST_BYTE;
      cap0_lo <= RST_BYTE;
      cap1_hi <= RST_BYTE;
      cap1_lo <= RST_BYTE;
      cmp0_hi <= RST_BYTE;
      cmp0_lo <= RST_BYTE;
      cmp1_hi <= RST_BYTE;
      cmp1_lo <= RST_BYTE;
    end
    else
    begin
      if (cap0_ev)
        {cap0_hi, cap0_lo} <= counter;
      else
      begin
        if (w_cap0h) cap0_hi <= wb;
        if (w_cap0l) cap0_lo <= wb;
      end
      if (cap1_ev)
        {cap1_hi, cap1_lo} <= counter;
      else
      begin
        if (w_cap1h) cap1_hi <= wb;
        if (w_cap1l) cap1_lo <= wb;
      end
      if (ack & sel_cmp & (state == XFER_FIRST))
        cmp0_hi <= dma_in.wr_byte;
      else if (w_cmp0h)
        cmp0_hi <= wb;
      if (done_cmp)
        cmp0_lo <= dma_in.wr_byte;
      else if (w_cmp0l)
        cmp0_lo <= wb;
      if (w_cmp1h) cmp1_hi <= wb;
      if (w_cmp1l) cmp1_lo <= wb;
    end
  end

  // counter control and central run bit
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      run_en     <= 1'b0;
      clr_on_cap <= 1'b0;
      clr_on_cmp <= 1'b0;
      dir_sel    <= 1'b0;
      clear_req  <= 1'b0;
      glob_run   <= 1'b1;
    end
    else
    begin
      clear_req <= w_ctrl & wb[CTRL_CLEAR];
      if (w_ctrl)
      begin
        run_en     <= wb[CTRL_RUN_EN];
        clr_on_cap <= wb[CTRL_CLR_CAP];
        clr_on_cmp <= wb[CTRL_CLR_CMP];
        dir_sel    <= wb[CTRL_DIR_SEL];
      end
      if (w_cent)
        glob_run <= wb[0];
    end
  end

  // pointers, masks and dma control; hardware toggles win over software writes
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_ptr  <= RST_BYTE;
      addr_ptr <= RST_BYTE;
      dma_mask <= 4'h0;
      eob_cap  <= 1'b0;
      eob_cmp  <= 1'b0;
      swap_en  <= 1'b0;
      prio     <= PRIO_TOP;
    end
    else
    begin
      if (w_cptr) cnt_ptr <= {wb[7:2], 1'b0, wb[0]};
      if (eob_m & swap_en) cnt_ptr[2] <= ~cnt_ptr[2];
      if (w_aptr) addr_ptr <= {wb[7:2], 1'b0, wb[0]};
      if (eob_c & swap_en) addr_ptr[2] <= ~addr_ptr[2];
      // protection overrides a same-cycle re-enable so a stale pointer pair is never used
      if (w_mask) dma_mask <= wb[3:0];
      if (prot_cap) dma_mask[MASK_CAP_DMA] <= 1'b0;
      if (prot_cmp) dma_mask[MASK_CMP_DMA] <= 1'b0;
      eob_cap <= eob_c | (w_dctl ? wb[DCTL_EOB_CAP] : eob_cap);
      eob_cmp <= eob_m | (w_dctl ? wb[DCTL_EOB_CMP] : eob_cmp);
      if (w_dctl)
      begin
        swap_en <= wb[DCTL_SWAP];
        prio    <= wb[DCTL_PRIO_LSB+2:DCTL_PRIO_LSB];
      end
    end
  end

  // pending and overrun flags; a set in the clearing cycle wins
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pend_cap <= 1'b0;
      pend_cmp <= 1'b0;
      ovr_cap  <= 1'b0;
      ovr_cmp  <= 1'b0;
    end
    else
    begin
      pend_cap <= ev_cap | (w_flag ? wb[FLAG_PEND_CAP] : pend_cap);
      pend_cmp <= ev_cmp | (w_flag ? wb[FLAG_PEND_CMP] : pend_cmp);
      ovr_cap  <= (ev_cap & pend_cap) | (w_flag ? wb[FLAG_OVR_CAP] : ovr_cap);
      ovr_cmp  <= (ev_cmp & pend_cmp) | (w_flag ? wb[FLAG_OVR_CMP] : ovr_cmp);
    end
  end

  // word transfer engine and requests
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state   <= XFER_IDLE;
      sel_cmp <= 1'b0;
      req_cap <= 1'b0;
      req_cmp <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      sel_cmp <= next_sel;
      req_cap <= next_rcap;
      req_cmp <= next_rcmp;
    end
  end

  // registered outputs toward the dma controller and interrupt controller
  // capture bytes are sampled per byte; a capture between them splits the word
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      dma_out      <= '0;
      irq_capture0 <= 1'b0;
      irq_compare0 <= 1'b0;
    end
    else
    begin
      dma_out.req_capture <= next_rcap;
      dma_out.req_compare <= next_rcmp;
      dma_out.sel_compare <= next_sel;
      dma_out.high_byte   <= next_high;
      dma_out.prio        <= next_prio;
      dma_out.cnt_ptr     <= next_cptr;
      dma_out.addr_ptr    <= next_aptr;
      dma_out.rd_byte     <= next_high ? cap0_hi : cap0_lo;
      irq_capture0        <= pend_cap & dma_mask[MASK_CAP_IRQ];
      irq_compare0        <= pend_cmp & dma_mask[MASK_CMP_IRQ];
    end
  end

endmodule
